// [rtl/wlrtd_cfg.svh]
// Purpose: Constants for the accumulator-to-control-register transfer decoder
// Assumes: 10-bit instruction words, 4-bit accumulator
// Notes: Opcodes are full 10-bit matches
`ifndef WLRTD_CFG_SVH
`define WLRTD_CFG_SVH

// ==========================================
// Opcodes
`define WLRTD_OP_WAKEUP_CTL0 10'h21B
`define WLRTD_OP_WAKEUP_CTL1 10'h214
`define WLRTD_OP_WAKEUP_CTL2 10'h215
`define WLRTD_OP_LCD_CTL1 10'h20A

// ==========================================
// Reset values and widths
`define WLRTD_OP_W 10
`define WLRTD_ACC_W 4
`define WLRTD_CTL_RESET 4'h0
`define WLRTD_FLAG_RESET 1'b0
`define WLRTD_PC_STEP 1

`endif

// [rtl/wlrtd_pkg.sv]
// Purpose: Types for the transfer decoder
// Assumes: Constants come from wlrtd_cfg.svh
// Notes: Nothing here is imported
`default_nettype none
`include "wlrtd_cfg.svh"

package wlrtd_pkg;

  // ==========================================
  // Decoded transfer targets, one-hot
  typedef enum logic [4:0] {
    WLRTD_T_NONE  = 5'b0_0001,
    WLRTD_T_WAKE0 = 5'b0_0010,
    WLRTD_T_WAKE1 = 5'b0_0100,
    WLRTD_T_WAKE2 = 5'b0_1000,
    WLRTD_T_LCD1  = 5'b1_0000
  } wlrtd_target_t;

  // ==========================================
  // Per-instruction effect bundle
  typedef struct packed {
    logic hit;
    logic pc_advance;
    logic skip_next;
    logic carry_write;
  } wlrtd_effect_t;

endpackage
`default_nettype wire

// [rtl/wlrtd_decode.sv]
// Purpose: Combinational opcode decode for the four transfer instructions
// Assumes: Opcode is stable while valid is high
// Notes: Unknown opcodes decode to no target
`timescale 1ns/100ps
`default_nettype none
`include "wlrtd_cfg.svh"

module wlrtd_decode (
  input wire logic [`WLRTD_OP_W-1:0] opcode_in, // Instruction word
  input wire logic valid_in, // Word valid this cycle
  output wlrtd_pkg::wlrtd_target_t target_out, // Decoded target
  output wlrtd_pkg::wlrtd_effect_t effect_out // Side effects
);

  always_comb begin
    target_out = wlrtd_pkg::WLRTD_T_NONE;
    if (valid_in) begin
      case (opcode_in)
        `WLRTD_OP_WAKEUP_CTL0: target_out = wlrtd_pkg::WLRTD_T_WAKE0;
        `WLRTD_OP_WAKEUP_CTL1: target_out = wlrtd_pkg::WLRTD_T_WAKE1;
        `WLRTD_OP_WAKEUP_CTL2: target_out = wlrtd_pkg::WLRTD_T_WAKE2;
        `WLRTD_OP_LCD_CTL1: target_out = wlrtd_pkg::WLRTD_T_LCD1;
        default: target_out = wlrtd_pkg::WLRTD_T_NONE;
      endcase
    end
  end

  // Transfers never skip and never touch carry
  always_comb begin
    effect_out.hit = (target_out != wlrtd_pkg::WLRTD_T_NONE);
    effect_out.pc_advance = (target_out != wlrtd_pkg::WLRTD_T_NONE);
    effect_out.skip_next = 1'b0;
    effect_out.carry_write = 1'b0;
  end

endmodule // wlrtd_decode
`default_nettype wire

// [rtl/wlrtd_top.sv]
// Purpose: Executes accumulator-to-control-register transfer instructions
// Assumes: Fetch stage on mclk_in presents one word per cycle with valid
// Notes: Each instruction completes in the cycle it is presented
//
// Operation
// - Opcode 21B copies accumulator into wakeup_ctl0
// - Opcode 214 copies accumulator into wakeup_ctl1
// - Opcode 215 copies accumulator into wakeup_ctl2
// - Opcode 20A copies accumulator into lcd_ctl1
`timescale 1ns/100ps
`default_nettype none
`include "wlrtd_cfg.svh"

module wlrtd_top (
  input wire logic mclk_in, // Core clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic [`WLRTD_OP_W-1:0] opcode_in, // Fetched instruction word
  input wire logic op_valid_in, // Instruction word valid
  input wire logic [`WLRTD_ACC_W-1:0] acc_in, // Accumulator contents
  input wire logic carry_flag_in, // Carry flag from core
  output logic [`WLRTD_ACC_W-1:0] wakeup_ctl0_out, // Key-on wakeup control 0
  output logic [`WLRTD_ACC_W-1:0] wakeup_ctl1_out, // Key-on wakeup control 1
  output logic [`WLRTD_ACC_W-1:0] wakeup_ctl2_out, // Key-on wakeup control 2
  output logic [`WLRTD_ACC_W-1:0] lcd_ctl1_out, // LCD control 1
  output logic carry_flag_out, // Carry flag, passed unchanged
  output logic done_out, // Transfer executed last cycle
  output logic pc_inc_out, // Advance PC by one word
  output logic skip_out // Skip next instruction
);

  wlrtd_pkg::wlrtd_target_t target;
  wlrtd_pkg::wlrtd_effect_t effect;
  logic [`WLRTD_ACC_W-1:0] wake0_q;
  logic [`WLRTD_ACC_W-1:0] wake1_q;
  logic [`WLRTD_ACC_W-1:0] wake2_q;
  logic [`WLRTD_ACC_W-1:0] lcd1_q;
  logic carry_q;
  logic done_q;
  logic pc_inc_q;
  logic skip_q;

  // ==========================================
  // Decode
  wlrtd_decode u_decode (
    .opcode_in(opcode_in),
    .valid_in(op_valid_in),
    .target_out(target),
    .effect_out(effect)
  );

  // ==========================================
  // Control registers, single-cycle write
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wake0_q <= `WLRTD_CTL_RESET;
    end else if (target == wlrtd_pkg::WLRTD_T_WAKE0) begin
      wake0_q <= acc_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wake1_q <= `WLRTD_CTL_RESET;
    end else if (target == wlrtd_pkg::WLRTD_T_WAKE1) begin
      wake1_q <= acc_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wake2_q <= `WLRTD_CTL_RESET;
    end else if (target == wlrtd_pkg::WLRTD_T_WAKE2) begin
      wake2_q <= acc_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lcd1_q <= `WLRTD_CTL_RESET;
    end else if (target == wlrtd_pkg::WLRTD_T_LCD1) begin
      lcd1_q <= acc_in;
    end
  end

  // ==========================================
  // Core side effects
  // Carry is only ever reflected, so a transfer cannot disturb it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      carry_q <= `WLRTD_FLAG_RESET;
    end else begin
      carry_q <= carry_flag_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      done_q <= `WLRTD_FLAG_RESET;
      pc_inc_q <= `WLRTD_FLAG_RESET;
      skip_q <= `WLRTD_FLAG_RESET;
    end else begin
      done_q <= effect.hit;
      pc_inc_q <= effect.pc_advance;
      skip_q <= effect.skip_next;
    end
  end

  assign wakeup_ctl0_out = wake0_q;
  assign wakeup_ctl1_out = wake1_q;
  assign wakeup_ctl2_out = wake2_q;
  assign lcd_ctl1_out = lcd1_q;
  assign carry_flag_out = carry_q;
  assign done_out = done_q;
  assign pc_inc_out = pc_inc_q;
  assign skip_out = skip_q;

  // ==========================================
  // Checks
  sequence issue_s(logic [`WLRTD_OP_W-1:0] op);
    op_valid_in && opcode_in == op;
  endsequence

  wake0_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_WAKEUP_CTL0) |=> wakeup_ctl0_out == $past(acc_in) && done_out)
    else $error("wakeup_ctl0 not loaded");
  wake1_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_WAKEUP_CTL1) |=> wakeup_ctl1_out == $past(acc_in) && done_out)
    else $error("wakeup_ctl1 not loaded");
  wake2_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_WAKEUP_CTL2) |=> wakeup_ctl2_out == $past(acc_in) && done_out)
    else $error("wakeup_ctl2 not loaded");
  lcd1_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_LCD_CTL1) |=> lcd_ctl1_out == $past(acc_in) && done_out)
    else $error("lcd_ctl1 not loaded");
  wake0_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !(op_valid_in && opcode_in == `WLRTD_OP_WAKEUP_CTL0) |=> $stable(wakeup_ctl0_out))
    else $error("wakeup_ctl0 changed without its opcode");
  lcd1_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !(op_valid_in && opcode_in == `WLRTD_OP_LCD_CTL1) |=> $stable(lcd_ctl1_out))
    else $error("lcd_ctl1 changed without its opcode");
  carry_kept_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    1'b1 |=> carry_flag_out == $past(carry_flag_in))
    else $error("carry altered");
  no_skip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    done_out |-> pc_inc_out && !skip_out)
    else $error("transfer skipped or PC not advanced");
  wake1_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !(op_valid_in && opcode_in == `WLRTD_OP_WAKEUP_CTL1) |=> $stable(wakeup_ctl1_out))
    else $error("wakeup_ctl1 changed without its opcode");
  wake2_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !(op_valid_in && opcode_in == `WLRTD_OP_WAKEUP_CTL2) |=> $stable(wakeup_ctl2_out))
    else $error("wakeup_ctl2 changed without its opcode");

  // Any transfer encoding with valid; ignored words are its complement
  sequence any_issue_s;
    op_valid_in && (opcode_in == `WLRTD_OP_WAKEUP_CTL0 ||
      opcode_in == `WLRTD_OP_WAKEUP_CTL1 ||
      opcode_in == `WLRTD_OP_WAKEUP_CTL2 ||
      opcode_in == `WLRTD_OP_LCD_CTL1);
  endsequence

  sequence no_issue_s;
    !(op_valid_in && (opcode_in == `WLRTD_OP_WAKEUP_CTL0 ||
      opcode_in == `WLRTD_OP_WAKEUP_CTL1 ||
      opcode_in == `WLRTD_OP_WAKEUP_CTL2 ||
      opcode_in == `WLRTD_OP_LCD_CTL1));
  endsequence

  // Transfer then an ignored word: pulse must not stretch
  sequence lone_issue_s;
    any_issue_s ##1 no_issue_s;
  endsequence

  // ==========================================
  // Completion and core side effects
  done_taken_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    any_issue_s |=> done_out && pc_inc_out)
    else $error("transfer not reported complete");
  done_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    no_issue_s |=> !done_out && !pc_inc_out)
    else $error("completion reported without a transfer");
  pulse_single_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    lone_issue_s |-> done_out ##1 (!done_out && !pc_inc_out))
    else $error("completion pulse stretched");
  skip_never_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !skip_out)
    else $error("skip raised");
  pc_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    pc_inc_out == done_out)
    else $error("PC advance differs from completion");
  effect_clean_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    effect.hit |-> !effect.carry_write && !effect.skip_next)
    else $error("transfer decoded with carry or skip effect");

  // ==========================================
  // Only the addressed register may move
  target_onehot_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $onehot(target))
    else $error("decoded target not one-hot");
  wake0_alone_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_WAKEUP_CTL0) |=> $stable(wakeup_ctl1_out) && $stable(wakeup_ctl2_out)
      && $stable(lcd_ctl1_out))
    else $error("wakeup_ctl0 transfer disturbed another register");
  wake1_alone_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_WAKEUP_CTL1) |=> $stable(wakeup_ctl0_out) && $stable(wakeup_ctl2_out)
      && $stable(lcd_ctl1_out))
    else $error("wakeup_ctl1 transfer disturbed another register");
  wake2_alone_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_WAKEUP_CTL2) |=> $stable(wakeup_ctl0_out) && $stable(wakeup_ctl1_out)
      && $stable(lcd_ctl1_out))
    else $error("wakeup_ctl2 transfer disturbed another register");
  lcd1_alone_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    issue_s(`WLRTD_OP_LCD_CTL1) |=> $stable(wakeup_ctl0_out) && $stable(wakeup_ctl1_out)
      && $stable(wakeup_ctl2_out))
    else $error("lcd_ctl1 transfer disturbed another register");
  acc_ignored_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    no_issue_s |=> $stable(wakeup_ctl0_out) && $stable(wakeup_ctl1_out)
      && $stable(wakeup_ctl2_out) && $stable(lcd_ctl1_out))
    else $error("ignored word changed a control register");

  // No disable here, so that the reset itself is watched
  reset_clear_a: assert property (@(posedge mclk_in)
    rst_in |=> wakeup_ctl0_out == `WLRTD_CTL_RESET && wakeup_ctl1_out == `WLRTD_CTL_RESET
      && wakeup_ctl2_out == `WLRTD_CTL_RESET && lcd_ctl1_out == `WLRTD_CTL_RESET
      && !carry_flag_out && !done_out && !pc_inc_out && !skip_out)
    else $error("outputs not cleared by reset");

endmodule // wlrtd_top
`default_nettype wire

// [testbench/wlrtd_fetch_model.sv]
// Purpose: Fetch stage model feeding instruction words to the decoder
// Assumes: One word per call, driven 1 ns after the rising edge
// Notes: Holds each word until the next call
`timescale 1ns/100ps
`default_nettype none
`include "wlrtd_cfg.svh"

module wlrtd_fetch_model (
  input wire logic mclk_in, // Core clock
  output logic [`WLRTD_OP_W-1:0] opcode_out, // Instruction word
  output logic op_valid_out, // Word valid
  output logic [`WLRTD_ACC_W-1:0] acc_out, // Accumulator contents
  output logic carry_out // Carry flag
);
  initial begin
    opcode_out = 10'h3FF;
    op_valid_out = 1'b0;
    acc_out = 4'h0;
    carry_out = 1'b0;
  end

  // Stalls are issued as words with valid low; the word stays visible
  task automatic issue(input logic v, input logic [9:0] op, input logic [3:0] a, input logic c);
    @(posedge mclk_in);
    #1;
    op_valid_out = v;
    opcode_out = op;
    acc_out = a;
    carry_out = c;
  endtask
endmodule // wlrtd_fetch_model
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the transfer decoder
// Assumes: Results visible one edge after the word is taken
// Notes: Each step checks the word issued before it
`timescale 1ns/100ps
`default_nettype none
`include "wlrtd_cfg.svh"

module tb_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] opcode;
  logic op_valid;
  logic [3:0] acc, wake0, wake1, wake2, lcd1;
  logic carry, carry_seen, done, pc_inc, skip;
  int miscompares = 0;
  int checked = 0;
  logic [3:0] exp_q [4];
  logic exp_done = 1'b0;
  logic exp_carry = 1'b0;

  always #5 mclk_in = ~mclk_in;

  wlrtd_fetch_model FETCH (.mclk_in(mclk_in), .opcode_out(opcode), .op_valid_out(op_valid),
    .acc_out(acc), .carry_out(carry));
  wlrtd_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .opcode_in(opcode),
    .op_valid_in(op_valid), .acc_in(acc), .carry_flag_in(carry), .wakeup_ctl0_out(wake0),
    .wakeup_ctl1_out(wake1), .wakeup_ctl2_out(wake2), .lcd_ctl1_out(lcd1),
    .carry_flag_out(carry_seen),
    .done_out(done), .pc_inc_out(pc_inc), .skip_out(skip));

  // ==========================================
  // Checking helpers
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic compare_all;
    check("wakeup_ctl0", wake0, exp_q[0]);
    check("wakeup_ctl1", wake1, exp_q[1]);
    check("wakeup_ctl2", wake2, exp_q[2]);
    check("lcd_ctl1", lcd1, exp_q[3]);
    check("done", {3'h0, done}, {3'h0, exp_done});
    check("pc_inc", {3'h0, pc_inc}, {3'h0, exp_done});
    check("skip", {3'h0, skip}, 4'h0);
    check("carry", {3'h0, carry_seen}, {3'h0, exp_carry});
  endtask

  task automatic step(input logic v, input logic [9:0] op, input logic [3:0] a, input logic c);
    FETCH.issue(v, op, a, c);
    compare_all();
    exp_done = 1'b0;
    exp_carry = c;
    if (v) begin
      exp_done = 1'b1;
      case (op)
        `WLRTD_OP_WAKEUP_CTL0: exp_q[0] = a;
        `WLRTD_OP_WAKEUP_CTL1: exp_q[1] = a;
        `WLRTD_OP_WAKEUP_CTL2: exp_q[2] = a;
        `WLRTD_OP_LCD_CTL1: exp_q[3] = a;
        default: exp_done = 1'b0;
      endcase
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic test_reset;
    FETCH.issue(1'b1, `WLRTD_OP_WAKEUP_CTL0, 4'h9, 1'b1);
    rst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    exp_q = '{default: 4'h0};
    exp_done = 1'b0;
    exp_carry = 1'b0;
    compare_all();
    FETCH.issue(1'b0, 10'h000, 4'h0, 1'b0);
    rst_in = 1'b0;
    $display("test reset done");
  endtask

  // Back to back, every target twice, carry toggling underneath
  task automatic test_transfers;
    logic [9:0] ops [4];
    ops = '{`WLRTD_OP_WAKEUP_CTL0, `WLRTD_OP_WAKEUP_CTL1, `WLRTD_OP_WAKEUP_CTL2,
      `WLRTD_OP_LCD_CTL1};
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        step(1'b1, ops[i], r[0] ? ~(4'(i) + 4'h5) : 4'(i) + 4'h5, 1'(i + r));
      end
    end
    step(1'b0, 10'h000, 4'h0, 1'b1);
    $display("test transfers done");
  endtask

  // Valid low on a real opcode, then near misses of each encoding
  task automatic test_refused;
    step(1'b0, `WLRTD_OP_WAKEUP_CTL0, 4'hF, 1'b1);
    step(1'b1, 10'h31B, 4'hF, 1'b0);
    step(1'b1, 10'h21A, 4'hF, 1'b1);
    step(1'b1, 10'h216, 4'hF, 1'b0);
    step(1'b1, 10'h00A, 4'hF, 1'b1);
    step(1'b0, `WLRTD_OP_LCD_CTL1, 4'hF, 1'b0);
    step(1'b0, 10'h000, 4'h0, 1'b0);
    $display("test refused done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    exp_q = '{default: 4'h0};
    repeat (10) @(posedge mclk_in);
    test_reset();
    test_transfers();
    test_refused();
    test_reset();
    test_transfers();
    summarize();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
